// [hdl/gp4_top.sv]
`timescale 1ns/10ps
`include "gp4_defines.svh"
module gp4_top (
	input  wire logic                        clk,
	input  wire logic                        rst,
	input  wire logic                        wb_cyc_i,
	input  wire logic                        wb_stb_i,
	input  wire logic                        wb_we_i,
	input  wire logic [7:0]                  wb_adr_i,
	input  wire logic [3:0]                  wb_sel_i,
	input  wire logic [31:0]                 wb_dat_i,
	output logic      [31:0]                 wb_dat_o,
	output logic                             wb_ack_o,
	input  wire logic [23:0]                 pin_in,
	output gp4_pkg::gp4_pads_type            pads_o,
	input  wire gp4_pkg::gp4_periph_out_type periph_out_i,
	output gp4_pkg::gp4_periph_in_type       periph_in_o
);
	logic [7:0] latch0_reg;
	logic [5:0] latch1_reg;
	logic [7:0] latch2_reg;
	logic [1:0] latch3_reg;
	logic [7:0] dir0_reg;
	logic [5:0] dir1_reg;
	logic [7:0] dir2_reg;
	logic [1:0] dir3_reg;
	logic [7:0] pu_shared_reg;
	logic [7:0] pu_p2_reg;
	logic [9:0] alt_sel_reg;
	logic [31:0] dat_next;
	logic [23:0] pin_sync;

	wire [5:0] idx;
	wire       access;
	wire       wr_stb;
	wire       rd_stb;
	wire [3:0] wr_port;
	wire [3:0] rd_port;
	wire       wr_dir;
	wire [7:0] pin0;
	wire [5:0] pin1;
	wire [7:0] pin2;
	wire [1:0] pin3;
	wire [7:0] alt_p2_val;
	wire [1:0] alt_p3_val;
	wire [7:0] alt_p2_en;

	function automatic logic [7:0] port_read(input logic [7:0] latch, input logic [7:0] dir,
		input logic [7:0] pin);
		port_read = (latch & ~dir) | (pin & dir);
	endfunction

	// Bus decode; a new access only starts while ack is low
	assign idx    = wb_adr_i[7:2];
	assign access = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr_stb = access & wb_we_i & wb_sel_i[0];
	assign rd_stb = access & ~wb_we_i;
	assign wr_port[0] = wr_stb & (idx == `GP4_IDX_DATA0);
	assign wr_port[1] = wr_stb & (idx == `GP4_IDX_DATA1);
	assign wr_port[2] = wr_stb & (idx == `GP4_IDX_DATA2);
	assign wr_port[3] = wr_stb & (idx == `GP4_IDX_DATA3);
	assign rd_port[0] = rd_stb & (idx == `GP4_IDX_DATA0);
	assign rd_port[1] = rd_stb & (idx == `GP4_IDX_DATA1);
	assign rd_port[2] = rd_stb & (idx == `GP4_IDX_DATA2);
	assign rd_port[3] = rd_stb & (idx == `GP4_IDX_DATA3);
	assign wr_dir = wr_stb;

	assign pin0 = pin_sync[`GP4_LSB_P0 +: 8];
	assign pin1 = pin_sync[`GP4_LSB_P1 +: 6];
	assign pin2 = pin_sync[`GP4_LSB_P2 +: 8];
	assign pin3 = pin_sync[`GP4_LSB_P3 +: 2];

	// Only output-capable alternate functions can take a pin
	assign alt_p2_val = {periph_out_i.timer_a_out, 5'h00, periph_out_i.serial_data_out_pin,
		periph_out_i.serial_clock_pin};
	assign alt_p3_val = {periph_out_i.buzzer_output, periph_out_i.timer_b_output};
	assign alt_p2_en  = alt_sel_reg[7:0] & `GP4_ALT_P2_MASK;

	// Read mux; pin levels for inputs, latch for outputs
	always_comb begin
		dat_next = 32'h0000_0000;
		case (idx)
			`GP4_IDX_DATA0: dat_next[7:0] = port_read(latch0_reg, dir0_reg, pin0);
			`GP4_IDX_DATA1: dat_next[7:0] = port_read({2'h0, latch1_reg}, {2'h3, dir1_reg},
				{2'h0, pin1});
			`GP4_IDX_DATA2: dat_next[7:0] = port_read(latch2_reg, dir2_reg, pin2);
			`GP4_IDX_DATA3: dat_next[7:0] = port_read({6'h00, latch3_reg}, {6'h3f, dir3_reg},
				{6'h00, pin3});
			`GP4_IDX_DIR0:  dat_next[7:0] = dir0_reg;
			`GP4_IDX_DIR1:  dat_next[7:0] = {2'h3, dir1_reg};
			`GP4_IDX_DIR2:  dat_next[7:0] = dir2_reg;
			`GP4_IDX_DIR3:  dat_next[7:0] = {6'h3f, dir3_reg};
			`GP4_IDX_PU_SH: dat_next[7:0] = pu_shared_reg;
			`GP4_IDX_PU_P2: dat_next[7:0] = pu_p2_reg;
			`GP4_IDX_ALT:   dat_next[9:0] = alt_sel_reg;
			default:        dat_next = 32'h0000_0000;
		endcase
	end

	// Unmapped addresses still ack, read zero and ignore writes
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= access;
			if (rd_stb) begin
				wb_dat_o <= dat_next;
			end
		end
	end

	// Latches load on write strobe only; reads never touch them
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			latch0_reg <= `GP4_LATCH_RST;
			latch1_reg <= 6'(`GP4_LATCH_RST);
			latch2_reg <= `GP4_LATCH_RST;
			latch3_reg <= 2'(`GP4_LATCH_RST);
		end else begin
			if (wr_port[0]) latch0_reg <= wb_dat_i[7:0];
			if (wr_port[1]) latch1_reg <= wb_dat_i[5:0];
			if (wr_port[2]) latch2_reg <= wb_dat_i[7:0];
			if (wr_port[3]) latch3_reg <= wb_dat_i[1:0];
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dir0_reg      <= `GP4_DIR_RST;
			dir1_reg      <= 6'(`GP4_DIR_RST);
			dir2_reg      <= `GP4_DIR_RST;
			dir3_reg      <= 2'(`GP4_DIR_RST);
			pu_shared_reg <= `GP4_PU_RST;
			pu_p2_reg     <= `GP4_PU_RST;
			alt_sel_reg   <= `GP4_ALT_RST;
		end else if (wr_dir) begin
			case (idx)
				`GP4_IDX_DIR0:  dir0_reg <= wb_dat_i[7:0];
				`GP4_IDX_DIR1:  dir1_reg <= wb_dat_i[5:0];
				`GP4_IDX_DIR2:  dir2_reg <= wb_dat_i[7:0];
				`GP4_IDX_DIR3:  dir3_reg <= wb_dat_i[1:0];
				// Unused shared bits held at zero
				`GP4_IDX_PU_SH: pu_shared_reg <= wb_dat_i[7:0] & `GP4_PU_SH_MASK;
				`GP4_IDX_PU_P2: pu_p2_reg <= wb_dat_i[7:0];
				`GP4_IDX_ALT:   alt_sel_reg <= wb_dat_i[9:0];
				default:        alt_sel_reg <= alt_sel_reg;
			endcase
		end
	end

	gp4_sync #(.WIDTH(`GP4_PINS)) u_sync (
		.clk      (clk),
		.rst      (rst),
		.async_in (pin_in),
		.sync_out (pin_sync)
	);

	gp4_port_pad #(.WIDTH(8), .PER_BIT(1'b0)) u_pad0 (
		.clk      (clk),
		.rst      (rst),
		.latch    (latch0_reg),
		.dir      (dir0_reg),
		.alt_en   (8'h00),
		.alt_val  (8'h00),
		.pu_group (pu_shared_reg[`GP4_PU_BIT_P0]),
		.pu_bits  (8'h00),
		.pad_out  (pads_o.out[`GP4_LSB_P0 +: 8]),
		.pad_oe   (pads_o.oe[`GP4_LSB_P0 +: 8]),
		.pad_pu   (pads_o.pu[`GP4_LSB_P0 +: 8])
	);

	gp4_port_pad #(.WIDTH(6), .PER_BIT(1'b0)) u_pad1 (
		.clk      (clk),
		.rst      (rst),
		.latch    (latch1_reg),
		.dir      (dir1_reg),
		.alt_en   (6'h00),
		.alt_val  (6'h00),
		.pu_group (pu_shared_reg[`GP4_PU_BIT_P1]),
		.pu_bits  (6'h00),
		.pad_out  (pads_o.out[`GP4_LSB_P1 +: 6]),
		.pad_oe   (pads_o.oe[`GP4_LSB_P1 +: 6]),
		.pad_pu   (pads_o.pu[`GP4_LSB_P1 +: 6])
	);

	gp4_port_pad #(.WIDTH(8), .PER_BIT(1'b1)) u_pad2 (
		.clk      (clk),
		.rst      (rst),
		.latch    (latch2_reg),
		.dir      (dir2_reg),
		.alt_en   (alt_p2_en),
		.alt_val  (alt_p2_val),
		.pu_group (1'b0),
		.pu_bits  (pu_p2_reg),
		.pad_out  (pads_o.out[`GP4_LSB_P2 +: 8]),
		.pad_oe   (pads_o.oe[`GP4_LSB_P2 +: 8]),
		.pad_pu   (pads_o.pu[`GP4_LSB_P2 +: 8])
	);

	gp4_port_pad #(.WIDTH(2), .PER_BIT(1'b0)) u_pad3 (
		.clk      (clk),
		.rst      (rst),
		.latch    (latch3_reg),
		.dir      (dir3_reg),
		.alt_en   (alt_sel_reg[9:8]),
		.alt_val  (alt_p3_val),
		.pu_group (pu_shared_reg[`GP4_PU_BIT_P3]),
		.pu_bits  (2'h0),
		.pad_out  (pads_o.out[`GP4_LSB_P3 +: 2]),
		.pad_oe   (pads_o.oe[`GP4_LSB_P3 +: 2]),
		.pad_pu   (pads_o.pu[`GP4_LSB_P3 +: 2])
	);

	// Peripheral inputs tap the synchronised pins; always live, whatever the direction
	assign periph_in_o.serial_clock_pin        = pin2[0];
	assign periph_in_o.serial_data_in_pin      = pin2[2];
	assign periph_in_o.serial_slave_select_pin = pin2[3];
	assign periph_in_o.ext_interrupt_0         = pin2[4];
	assign periph_in_o.ext_interrupt_1         = pin2[5];
	assign periph_in_o.ext_interrupt_2_capture = pin2[6];
	assign periph_in_o.timer_a_in              = pin2[7];

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	chk_p0_dir_oe: assert property (##1 pads_o.oe[7:0] == ~$past(dir0_reg))
		else $error("port0 enable does not follow direction");
	chk_p1_dir_oe: assert property (##1 pads_o.oe[13:8] == ~$past(dir1_reg))
		else $error("port1 enable does not follow direction");
	chk_p2_dir_oe: assert property (wr_stb && idx == `GP4_IDX_DIR2 |->
		##2 pads_o.oe[21:14] == ~$past(wb_dat_i[7:0], 2))
		else $error("port2 direction write not seen at pins");
	chk_p2_oe_follow: assert property (##1 pads_o.oe[21:14] == ~$past(dir2_reg))
		else $error("port2 enable does not follow direction");
	chk_p3_dir_oe: assert property (##1 pads_o.oe[23:22] == ~$past(dir3_reg))
		else $error("port3 enable does not follow direction");
	// Reset checks stay live through reset itself
	chk_reset_inputs: assert property (@(posedge clk) disable iff (1'b0)
		$fell(rst) |-> pads_o.oe == 24'h000000)
		else $error("driver enabled right after reset");
	chk_reset_regs: assert property (@(posedge clk) disable iff (1'b0)
		$fell(rst) |-> dir2_reg == `GP4_DIR_RST && alt_sel_reg == `GP4_ALT_RST)
		else $error("control registers not at reset values");

	chk_p0_pullup: assert property (##1 pads_o.pu[7:0] ==
		($past(dir0_reg) & {8{$past(pu_shared_reg[0])}}))
		else $error("port0 pull-up wrong");
	chk_p1_pullup: assert property (##1 pads_o.pu[13:8] ==
		($past(dir1_reg) & {6{$past(pu_shared_reg[1])}}))
		else $error("port1 pull-up wrong");
	chk_p3_pullup: assert property (##1 pads_o.pu[23:22] ==
		($past(dir3_reg) & {2{$past(pu_shared_reg[3])}}))
		else $error("port3 pull-up wrong");
	chk_p2_pu_write: assert property (wr_stb && idx == `GP4_IDX_PU_P2 |=>
		pu_p2_reg == $past(wb_dat_i[7:0]))
		else $error("port2 pull-up register not loaded");
	// Tap is two flops behind the pin; attempts just after reset are skipped
	chk_p2_sync_tap: assert property (!$past(rst) |->
		##1 periph_in_o.ext_interrupt_0 == $past(pin_in[`GP4_LSB_P2 + 4], 2))
		else $error("interrupt input tap wrong");
	chk_p3_alt_route: assert property (alt_sel_reg[9] && !dir3_reg[1] |=>
		pads_o.out[23] == $past(periph_out_i.buzzer_output))
		else $error("buzzer output not routed");
	chk_p3_pullup_out: assert property (!dir3_reg[0] |=> !pads_o.pu[22])
		else $error("pull-up on port3 output pin");
	chk_p0_pullup_out: assert property (!dir0_reg[0] |=> !pads_o.pu[0])
		else $error("pull-up on port0 output pin");
	chk_p2_pullup: assert property (##1 pads_o.pu[21:14] == $past(pu_p2_reg))
		else $error("port2 pull-up not per bit");
	chk_p2_pu_output: assert property (pu_p2_reg[0] && !dir2_reg[0] |=> pads_o.pu[14])
		else $error("port2 pull-up dropped on output pin");
	chk_latch_write: assert property (wr_port[0] |=> latch0_reg == $past(wb_dat_i[7:0]))
		else $error("port0 latch not loaded");
	chk_latch3_write: assert property (wr_port[3] |=> latch3_reg == $past(wb_dat_i[1:0]))
		else $error("port3 latch not loaded");
	chk_dir1_write: assert property (wr_stb && idx == `GP4_IDX_DIR1 |=>
		dir1_reg == $past(wb_dat_i[5:0]))
		else $error("port1 direction not loaded");
	chk_read_hold: assert property (rd_port[2] |=> $stable(latch2_reg) && wb_ack_o &&
		wb_dat_o[7:0] == $past(port_read(latch2_reg, dir2_reg, pin2)))
		else $error("port2 read wrong");
	chk_read_out_bit: assert property (rd_port[0] && !dir0_reg[0] |=>
		wb_dat_o[0] == $past(latch0_reg[0]))
		else $error("port0 output bit read wrong");
	chk_alt_route: assert property (alt_sel_reg[7] && !dir2_reg[7] |=>
		pads_o.out[21] == $past(periph_out_i.timer_a_out))
		else $error("alternate output not routed");
	chk_p2_latch_out: assert property (!alt_p2_en[2] |=>
		pads_o.out[16] == $past(latch2_reg[2]))
		else $error("port2 pin left latch without alternate");
	chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	chk_no_ack_idle: assert property (!wb_cyc_i |=> !wb_ack_o)
		else $error("ack without a request");

	cov_port_write: cover property (wr_port[1] ##1 wb_ack_o);
	cov_port_read: cover property (rd_port[0] && dir0_reg != 8'hff ##1 wb_ack_o);
	cov_alt_out: cover property (alt_sel_reg[8] && !dir3_reg[0]);
	cov_masked_write: cover property (access && wb_we_i && !wb_sel_i[0]);
	cov_p2_pull_out: cover property (pu_p2_reg[0] && !dir2_reg[0]);
endmodule

// [shared/gp4_defines.svh]
// Behaviour
// - Port zero: eight bidirectional pins, output latch, per-bit direction register.
// - Port one: six bidirectional pins, output latch, per-bit direction register.
// - Port two: eight bidirectional pins, output latch, per-bit direction register.
// - Port three: two bidirectional pins, output latch, per-bit direction register.
// - Reset makes every pin an input; no driver enabled.
// - Port zero pull-ups: one shared bit for all eight input pins.
// - Port one pull-ups: one shared bit for all six input pins.
// - Port three pull-ups: one shared bit for both input pins.
// - Port two pull-ups: enabled bit by bit from their own register.
// - Port two pins carry interrupt, serial and timer peripheral signals.
// - Port three pins carry timer and buzzer outputs.
// - Each port has read and write strobes; write loads latch, read drives bus.
// - Control registers: four direction registers and two pull-up registers.
// - Direction bit 0 means output driving; 1 means input, driver off.
// - Shared pull-up never applies to a pin in output mode.
// - Port two pull-up follows its enable bit, whatever the direction.
// - Read gives latch for outputs, pin level for inputs; latch unchanged.
`ifndef GP4_DEFINES_SVH
`define GP4_DEFINES_SVH

`define GP4_IDX_DATA0   6'h00
`define GP4_IDX_DATA1   6'h01
`define GP4_IDX_DATA2   6'h02
`define GP4_IDX_DATA3   6'h03
`define GP4_IDX_DIR0    6'h04
`define GP4_IDX_DIR1    6'h05
`define GP4_IDX_DIR2    6'h06
`define GP4_IDX_DIR3    6'h07
`define GP4_IDX_PU_SH   6'h08
`define GP4_IDX_PU_P2   6'h09
`define GP4_IDX_ALT     6'h0a

`define GP4_DIR_RST     8'hff
`define GP4_PU_RST      8'h00
`define GP4_LATCH_RST   8'h00
`define GP4_ALT_RST     10'h000
`define GP4_PU_SH_MASK  8'h0b
`define GP4_PU_BIT_P0   0
`define GP4_PU_BIT_P1   1
`define GP4_PU_BIT_P3   3
`define GP4_ALT_P2_MASK 8'h83

`define GP4_LSB_P0      0
`define GP4_LSB_P1      8
`define GP4_LSB_P2      14
`define GP4_LSB_P3      22
`define GP4_PINS        24

`endif

// [shared/gp4_pkg.sv]
package gp4_pkg;

	typedef struct packed {
		logic [23:0] out;
		logic [23:0] oe;
		logic [23:0] pu;
	} gp4_pads_type;

	typedef struct packed {
		logic serial_clock_pin;
		logic serial_data_in_pin;
		logic serial_slave_select_pin;
		logic ext_interrupt_0;
		logic ext_interrupt_1;
		logic ext_interrupt_2_capture;
		logic timer_a_in;
	} gp4_periph_in_type;

	typedef struct packed {
		logic serial_clock_pin;
		logic serial_data_out_pin;
		logic timer_a_out;
		logic timer_b_output;
		logic buzzer_output;
	} gp4_periph_out_type;

endpackage

// [hdl/gp4_sync.sv]
`timescale 1ns/10ps
module gp4_sync #(
	parameter int WIDTH = 24
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_reg;

	// First stage feeds only the second stage
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_reg <= '0;
			sync_out <= '0;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end
endmodule

// [hdl/gp4_port_pad.sv]
`timescale 1ns/10ps
module gp4_port_pad #(
	parameter int WIDTH   = 8,
	parameter bit PER_BIT = 1'b0
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] latch,
	input  wire logic [WIDTH-1:0] dir,
	input  wire logic [WIDTH-1:0] alt_en,
	input  wire logic [WIDTH-1:0] alt_val,
	input  wire logic             pu_group,
	input  wire logic [WIDTH-1:0] pu_bits,
	output logic      [WIDTH-1:0] pad_out,
	output logic      [WIDTH-1:0] pad_oe,
	output logic      [WIDTH-1:0] pad_pu
);
	wire [WIDTH-1:0] out_next;
	wire [WIDTH-1:0] oe_next;
	wire [WIDTH-1:0] pu_next;

	assign out_next = (alt_en & alt_val) | (~alt_en & latch);
	assign oe_next  = ~dir;
	// Group pull-up only on inputs; per-bit pull-up ignores direction
	assign pu_next  = PER_BIT ? pu_bits : ({WIDTH{pu_group}} & dir);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pad_out <= '0;
			pad_oe  <= '0;
			pad_pu  <= '0;
		end else begin
			pad_out <= out_next;
			pad_oe  <= oe_next;
			pad_pu  <= pu_next;
		end
	end
endmodule

// [dv/gp4_pin_model.sv]
`timescale 1ns/10ps
module gp4_pin_model (
	input  wire logic                  clk,
	input  wire gp4_pkg::gp4_pads_type pads,
	input  wire logic [23:0]           ext_val,
	input  wire logic [23:0]           ext_en,
	output logic      [23:0]           pin_in
);
	// Undriven pins without a pull-up wander each cycle so a stale level never passes for a real one
	logic [23:0] float_reg = 24'h5a5a5a;
	always @(posedge clk) begin
		float_reg <= ~float_reg;
	end
	always_comb begin
		for (int i = 0; i < 24; i++) begin
			pin_in[i] = pads.oe[i] ? pads.out[i] : ext_en[i] ? ext_val[i] :
				pads.pu[i] ? 1'b1 : float_reg[i];
		end
	end
endmodule

// [dv/test_four_port_gpio_bank.sv]
`timescale 1ns/10ps
module test_four_port_gpio_bank;
	logic                           clk;
	logic                           rst;
	logic                           cyc;
	logic                           stb;
	logic                           we;
	logic [7:0]                     adr;
	logic [31:0]                    dat;
	logic [31:0]                    wb_dat_o;
	logic                           wb_ack_o;
	logic [23:0]                    pin_in;
	logic [23:0]                    ext_val;
	logic [23:0]                    ext_en;
	gp4_pkg::gp4_periph_out_type    pout;
	gp4_pkg::gp4_pads_type          pads;
	gp4_pkg::gp4_periph_in_type     pin_o;
	logic [31:0]                    exp_q[$];
	int                             n_mismatch;
	int                             tests_run;
	int                             cyc_cnt;
	int                             seed;
	int                             wid[4] = '{8, 6, 8, 2};
	int                             lsb[4] = '{0, 8, 14, 22};
	logic [7:0]                     m;
	logic [7:0]                     d;
	logic [7:0]                     dm;
	logic [7:0]                     pv;
	logic [7:0]                     pub;
	logic [7:0]                     dirs[4];
	logic [7:0]                     lat[4];
	logic [3:0]                     sel;
	logic [3:0]                     sel_v;

	gp4_top DUT (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .pin_in(pin_in), .pads_o(pads), .periph_out_i(pout),
		.periph_in_o(pin_o));
	gp4_pin_model pins (.clk(clk), .pads(pads), .ext_val(ext_val), .ext_en(ext_en),
		.pin_in(pin_in));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wrap_up;
		$display("mismatches %0d checks %0d", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// Request held until ack is sampled; the bench timeout ends a hang
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= v;
		sel <= sel_v;
		do begin
			@(posedge clk);
		end while (wb_ack_o !== 1'b1);
		cyc <= 1'b0;
		stb <= 1'b0;
		#1;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		wb(1'b0, a, 32'h0);
	endtask

	always @(posedge clk) begin
		if (wb_ack_o === 1'b1 && we === 1'b0) begin
			chk(wb_dat_o, exp_q.pop_front());
		end
	end

	always @(posedge clk) begin
		cyc_cnt++;
		if (cyc_cnt == 5000) begin
			n_mismatch++;
			wrap_up;
		end
	end

	initial begin
		seed = 32'h5fcabbc3;
		rst = 1'b1;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		dat = 32'h0;
		sel = 4'h1;
		sel_v = 4'h1;
		ext_val = 24'h0;
		ext_en = 24'hffffff;
		pout = 5'h00;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		#1;
		chk(32'(pads.oe), 32'h0);
		chk(32'(pads.pu), 32'h0);
		for (int p = 0; p < 4; p++) begin
			rd(8'(16 + 4 * p), 32'hff);
		end
		rd(8'h20, 32'h0);
		rd(8'h24, 32'h0);
		for (int p = 0; p < 4; p++) begin
			m = 8'((1 << wid[p]) - 1);
			d = 8'($random(seed));
			dm = 8'($random(seed)) & m;
			dirs[p] = dm;
			lat[p] = d;
			@(posedge clk);
			ext_val <= 24'($random(seed));
			wb(1'b1, 8'(16 + 4 * p), 32'(dm));
			wb(1'b1, 8'(4 * p), 32'(d));
			chk(32'(8'(pads.oe >> lsb[p]) & m), 32'(~dm & m));
			chk(32'(8'(pads.out >> lsb[p]) & m), 32'(d & m));
			// Two sync flops plus the pad register before the pin reads back
			repeat (3) @(posedge clk);
			pv = (8'(ext_val >> lsb[p]) & dm) | (d & ~dm & m);
			rd(8'(4 * p), 32'(pv));
			chk(32'(8'(pads.out >> lsb[p]) & m), 32'(d & m));
			rd(8'(16 + 4 * p), {24'h0, dm | ~m});
			if (p == 2) begin
				chk(32'(pin_o), 32'({pv[0], pv[2], pv[3], pv[4], pv[5], pv[6], pv[7]}));
			end
		end
		wb(1'b1, 8'h20, 32'hff);
		rd(8'h20, 32'h0b);
		pub = 8'($random(seed));
		wb(1'b1, 8'h24, 32'(pub));
		chk(32'(pads.pu), 32'({dirs[3][1:0], pub, dirs[1][5:0], dirs[0]}));
		@(posedge clk);
		ext_en <= 24'hffff00;
		// Undriven port 0 inputs must read high through the group pull-up
		repeat (3) @(posedge clk);
		rd(8'h00, 32'(dirs[0] | (lat[0] & ~dirs[0])));
		sel_v = 4'h0;
		wb(1'b1, 8'h00, 32'(~lat[0]));
		sel_v = 4'h1;
		chk(32'(pads.out[7:0]), 32'(lat[0]));
		wb(1'b1, 8'h20, 32'h0);
		chk(32'(pads.pu), 32'({2'h0, pub, 14'h0}));
		wb(1'b1, 8'h18, 32'h0);
		wb(1'b1, 8'h1c, 32'h0);
		@(posedge clk);
		pout <= 5'($random(seed));
		wb(1'b1, 8'h28, 32'h383);
		chk(32'({pads.out[23:21], pads.out[15:14]}), 32'({pout.buzzer_output,
			pout.timer_b_output, pout.timer_a_out, pout.serial_data_out_pin,
			pout.serial_clock_pin}));
		rd(8'h28, 32'h383);
		wb(1'b1, 8'h2c, 32'hff);
		rd(8'h2c, 32'h0);
		// Reset in mid-run with ports 2 and 3 driving: every driver must drop
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		#1;
		chk(32'(pads.oe), 32'h0);
		chk(32'(pads.out), 32'h0);
		rd(8'h18, 32'hff);
		rd(8'h28, 32'h0);
		repeat (2) @(posedge clk);
		wrap_up;
	end
endmodule
